/* File: logic/afr_fault_ctrl.sv */
`timescale 1ns/10ps
`include "afr_defs.svh"

// How it works
// - shutdown_flag_n goes low whenever a fault has shut the power stage down.
// - temp_warn_n and temp_warn_high_n go low above 125C, temp_warn_low_n above 100C.
// - a fault puts the affected half-bridges in high impedance and pulls the shutdown flag low.
// - faults other than overload and overtemperature error clear themselves when gone.
// - while reset is low the shutdown flag is forced high whatever faults exist.
// - in bridge and single-ended modes A/B and C/D fail as pairs; in parallel mode all four.
// - a bootstrap undervoltage disables only its own half-bridge.
// - all half-bridges stay high impedance until gate-drive and common supplies are good.
// - while reset is low in bridge modes the weak output pulldown is on so bootstrap capacitors charge.
// - all four status pins high means normal operation with no fault and cool die.
// - overtemperature error and overload are latched until reset is asserted.
// - reset low forces all four half-bridges off, with pulldown only in bridge modes.
module afr_fault_ctrl (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic reset_pin_n_in,
    input wire logic [1:0] mode_in,
    input wire logic overtemp_error_in,
    input wire logic overload_protect_in,
    input wire logic temp_warn_low_in,
    input wire logic temp_warn_high_in,
    input wire logic gate_drive_supply_ok_in,
    input wire logic common_supply_ok_in,
    input wire logic [3:0] local_error_in,
    input wire logic [3:0] bootstrap_uv_in,
    output logic shutdown_flag_n_out,
    output logic shutdown_flag_n_oe_out,
    output logic temp_warn_n_out,
    output logic temp_warn_n_oe_out,
    output logic temp_warn_low_n_out,
    output logic temp_warn_low_n_oe_out,
    output logic temp_warn_high_n_out,
    output logic temp_warn_high_n_oe_out,
    output logic [3:0] hb_hiz_out,
    output logic [3:0] hb_pulldown_out,
    output logic [2:0] state_out
);
    ////////////////////////////////////////////////////////////////////////////
    localparam int NSYNC = 15;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn;
    logic rst_pin_n;
    logic overtemp_error;
    logic overload_protect;
    logic warn_lo;
    logic warn_hi;
    logic supply_ok;
    logic [3:0] loc_err;
    logic [3:0] bst_uv;
    logic [1:0] mode_q;
    logic ote_latch_q;
    logic olp_latch_q;
    logic [3:0] group_off;
    logic [3:0] hiz_d;
    logic any_fault;
    afr_pkg::afr_state_t state_q;

    assign raw_in = {reset_pin_n_in, overtemp_error_in, overload_protect_in, temp_warn_low_in,
        temp_warn_high_in, gate_drive_supply_ok_in, common_supply_ok_in,
        local_error_in, bootstrap_uv_in};

    // all pin-level inputs except mode_in double-flopped
    afr_sync #(
        .WIDTH(NSYNC)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(raw_in),
        .sync_out(syn)
    );

    assign rst_pin_n = syn[14];
    assign overtemp_error = syn[13];
    assign overload_protect = syn[12];
    assign warn_lo = syn[11];
    assign warn_hi = syn[10];
    assign supply_ok = syn[9] & syn[8];
    assign loc_err = syn[7:4];
    assign bst_uv = syn[3:0];

    ////////////////////////////////////////////////////////////////////////////
    // group expansion of local errors by output mode
    function automatic logic [3:0] afr_group(input logic [1:0] mode, input logic [3:0] err);
        logic ab;
        logic cd;
        ab = err[`AFR_HB_A] | err[`AFR_HB_B];
        cd = err[`AFR_HB_C] | err[`AFR_HB_D];
        if (mode == `AFR_MODE_PARALLEL_BRIDGE_MODE)
            afr_group = {4{ab | cd}};
        else
            afr_group = {cd, cd, ab, ab};
    endfunction

    // mode sampled only during reset; changing it while running would glitch pairing
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            mode_q <= `AFR_MODE_BTL;
        else if (!rst_pin_n)
            mode_q <= mode_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    // latched faults, cleared only by the reset pin or by rst_n_in; a new event while reset
    // is low is not stored since reset overrides the stage anyway
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            ote_latch_q <= 1'b0;
            olp_latch_q <= 1'b0;
        end
        else if (!rst_pin_n)
        begin
            ote_latch_q <= 1'b0;
            olp_latch_q <= 1'b0;
        end
        else
        begin
            ote_latch_q <= ote_latch_q | overtemp_error;
            olp_latch_q <= olp_latch_q | overload_protect;
        end
    end

    always_comb
    begin
        group_off = afr_group(mode_q, loc_err);
        // latched faults and bad supplies take down all four; others self-clear
        any_fault = ote_latch_q | olp_latch_q | ~supply_ok | (|loc_err) | (|bst_uv);
        hiz_d = group_off | bst_uv;
        if (ote_latch_q || olp_latch_q || !supply_ok || !rst_pin_n)
            hiz_d = 4'hF;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state is for observation only; the latch registers carry the shutdown
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            state_q <= afr_pkg::AFR_ST_RESET;
        else
        begin
            case (state_q)
                afr_pkg::AFR_ST_RESET:
                    if (rst_pin_n)
                        state_q <= afr_pkg::AFR_ST_RUN;
                afr_pkg::AFR_ST_RUN:
                    if (!rst_pin_n)
                        state_q <= afr_pkg::AFR_ST_RESET;
                    else if (overtemp_error || overload_protect)
                        state_q <= afr_pkg::AFR_ST_LATCHED;
                afr_pkg::AFR_ST_LATCHED:
                    if (!rst_pin_n)
                        state_q <= afr_pkg::AFR_ST_RESET;
                default:
                    state_q <= afr_pkg::AFR_ST_RESET;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            hb_hiz_out <= `AFR_HIZ_RST;
            state_out <= 3'h1;
        end
        else
        begin
            hb_hiz_out <= hiz_d;
            state_out <= state_q;
        end
    end

    // weak pulldown lets the bootstrap caps charge before switching starts
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
            hb_pulldown_out <= 4'h0;
        else
            // pulldown only in bridge modes, single-ended stays floating
            hb_pulldown_out <= (!rst_pin_n && mode_q != `AFR_MODE_SE) ? 4'hF : 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // open-drain pins: output value held low, enable pulls the line down
    // data bits registered too, so no pin ever sees a combinational path
    always_ff @(posedge sys_clk_in)
    begin
        shutdown_flag_n_out <= 1'b0;
        temp_warn_n_out <= 1'b0;
        temp_warn_low_n_out <= 1'b0;
        temp_warn_high_n_out <= 1'b0;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            shutdown_flag_n_oe_out <= ~`AFR_PIN_RST;
            temp_warn_n_oe_out <= ~`AFR_PIN_RST;
            temp_warn_low_n_oe_out <= ~`AFR_PIN_RST;
            temp_warn_high_n_oe_out <= ~`AFR_PIN_RST;
        end
        else
        begin
            // reset pin low releases the flag regardless of faults
            shutdown_flag_n_oe_out <= rst_pin_n & any_fault;
            temp_warn_n_oe_out <= warn_hi;
            temp_warn_high_n_oe_out <= warn_hi;
            temp_warn_low_n_oe_out <= warn_lo | warn_hi;
        end
    end
endmodule // afr_fault_ctrl

/* File: include/afr_defs.svh */
`ifndef AFR_DEFS_SVH
`define AFR_DEFS_SVH
// output mode codes
`define AFR_MODE_BTL 2'h0
`define AFR_MODE_PARALLEL_BRIDGE_MODE 2'h1
`define AFR_MODE_SE 2'h2
// half-bridge indices within the four-bit groups
`define AFR_HB_A 0
`define AFR_HB_B 1
`define AFR_HB_C 2
`define AFR_HB_D 3
// reset values of the status pins (released, pulled high) and of the half-bridges (all high impedance)
`define AFR_PIN_RST 1'h1
`define AFR_HIZ_RST 4'hF
`endif

/* File: include/afr_pkg.sv */
package afr_pkg;
    typedef enum logic [1:0] {
        AFR_BTL = 2'h0,
        AFR_PARALLEL_BRIDGE_MODE = 2'h1,
        AFR_SE = 2'h2
    } afr_mode_t;
    typedef enum logic [2:0] {
        AFR_ST_RESET = 3'h1,
        AFR_ST_RUN = 3'h2,
        AFR_ST_LATCHED = 3'h4
    } afr_state_t;
endpackage

/* File: logic/afr_sync.sv */
`timescale 1ns/10ps
module afr_sync #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    // first stage read only by the second stage
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // afr_sync

/* File: test/afr_fault_ctrl_asserts.sv */
`timescale 1ns/10ps
module afr_fault_ctrl_asserts (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic reset_pin_n_in,
    input wire logic [1:0] mode_in,
    input wire logic overtemp_error_in,
    input wire logic temp_warn_high_in,
    input wire logic gate_drive_supply_ok_in,
    input wire logic [3:0] local_error_in,
    input wire logic shutdown_flag_n_oe_out,
    input wire logic temp_warn_n_oe_out,
    input wire logic temp_warn_low_n_oe_out,
    input wire logic temp_warn_high_n_oe_out,
    input wire logic [3:0] hb_hiz_out,
    input wire logic [3:0] hb_pulldown_out,
    input wire logic [2:0] state_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_LOC_SD: assert property ((reset_pin_n_in && local_error_in != 4'h0) [*4] |->
        shutdown_flag_n_oe_out)
        else $error("local error did not pull flag");
    AST_WARN_PAIR: assert property (temp_warn_n_oe_out == temp_warn_high_n_oe_out)
        else $error("warn pins differ");
    AST_WARN_ORDER: assert property (temp_warn_high_n_oe_out |-> temp_warn_low_n_oe_out)
        else $error("high warn without low warn");
    AST_WARN_HIGH: assert property (temp_warn_high_in [*4] |-> temp_warn_high_n_oe_out)
        else $error("high warn late");
    AST_OTE_OFF: assert property ((overtemp_error_in && reset_pin_n_in) [*5] |->
        shutdown_flag_n_oe_out && hb_hiz_out == 4'hF)
        else $error("overtemp did not shut down");
    AST_LATCH_HOLD: assert property (reset_pin_n_in [*3] ##0 state_out == 3'h4 |=>
        state_out == 3'h4 && shutdown_flag_n_oe_out)
        else $error("latched fault lost");
    AST_RST_SD: assert property (!reset_pin_n_in [*4] |->
        !shutdown_flag_n_oe_out && hb_hiz_out == 4'hF)
        else $error("reset did not release flag");
    AST_UV_HIZ: assert property (!gate_drive_supply_ok_in [*4] |-> hb_hiz_out == 4'hF)
        else $error("low supply not hi-z");
    AST_PD_SE: assert property ((!reset_pin_n_in && mode_in == 2'h2) [*6] |->
        hb_pulldown_out == 4'h0)
        else $error("pulldown in single-ended");
    AST_PD_BR: assert property ((!reset_pin_n_in && mode_in != 2'h2) [*6] |->
        hb_pulldown_out == 4'hF)
        else $error("no pulldown in bridge");
endmodule // afr_fault_ctrl_asserts
bind afr_fault_ctrl afr_fault_ctrl_asserts chk_i (.*);

/* File: test/afr_ctrl_model.sv */
`timescale 1ns/10ps
module afr_ctrl_model #(
    // 4 ms at the 40 ns clock
    parameter int HOLD = 100000
) (
    input wire logic sys_clk_in,
    input wire logic sd_low_in,
    input wire logic warn_in,
    input wire logic hold_rst_in,
    output logic reset_pin_n_out
);
    int gap_q = HOLD;
    logic sd_low_q = 1'h0;
    logic vol_down_q = 1'h0;
    // gap counts from the flag's fall, not its release
    always_ff @(posedge sys_clk_in)
    begin
        sd_low_q <= sd_low_in;
        gap_q <= (sd_low_in && !sd_low_q) ? 0 : (gap_q < HOLD ? gap_q + 1 : gap_q);
    end
    // once released, only hold_rst_in pulls reset low again
    always_ff @(posedge sys_clk_in)
        reset_pin_n_out <= !hold_rst_in && (reset_pin_n_out || gap_q >= HOLD);
    always_ff @(posedge sys_clk_in)
        vol_down_q <= warn_in;
endmodule // afr_ctrl_model

/* File: test/afr_fault_ctrl_tb_top.sv */
`timescale 1ns/10ps
module afr_fault_ctrl_tb_top;
    logic sys_clk_in = 1'h0, rst_n_in = 1'h0, reset_pin_n_in, hold_rst = 1'h1;
    logic [1:0] mode_in = 2'h0;
    logic overtemp_error_in = 1'h0, overload_protect_in = 1'h0;
    logic temp_warn_low_in = 1'h0, temp_warn_high_in = 1'h0;
    logic gate_drive_supply_ok_in = 1'h1, common_supply_ok_in = 1'h1;
    logic [3:0] local_error_in = 4'h0, bootstrap_uv_in = 4'h0, hb_hiz_out, hb_pulldown_out;
    logic shutdown_flag_n_out, shutdown_flag_n_oe_out, temp_warn_n_out, temp_warn_n_oe_out;
    logic temp_warn_low_n_out, temp_warn_low_n_oe_out, temp_warn_high_n_out;
    logic temp_warn_high_n_oe_out;
    logic [2:0] state_out;
    int err_total = 0;
    int cmp_count = 0;
    always #20 sys_clk_in = ~sys_clk_in;
    afr_fault_ctrl dut (.*);
    // hold scaled down to keep the run short
    afr_ctrl_model #(.HOLD(20)) ctl (.sys_clk_in(sys_clk_in), .sd_low_in(shutdown_flag_n_oe_out),
        .warn_in(temp_warn_n_oe_out), .hold_rst_in(hold_rst), .reset_pin_n_out(reset_pin_n_in));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #2;
    endtask
    task automatic stat(input logic [3:0] hiz, input logic [2:0] oe);
        logic [2:0] pins;
        logic [3:0] dat;
        pins = {shutdown_flag_n_oe_out, temp_warn_low_n_oe_out, temp_warn_high_n_oe_out};
        dat = {shutdown_flag_n_out, temp_warn_n_out, temp_warn_low_n_out, temp_warn_high_n_out};
        chk({4'h0, hb_hiz_out}, {4'h0, hiz});
        chk({5'h0, pins}, {5'h0, oe});
        chk({7'h0, temp_warn_n_oe_out}, {7'h0, oe[0]});
        chk({4'h0, dat}, 8'h00);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic pin_reset();
        int i;
        hold_rst = 1'h1;
        tick(8);
        chk({7'h0, shutdown_flag_n_oe_out}, 8'h00);
        chk({4'h0, hb_pulldown_out}, mode_in == 2'h2 ? 8'h00 : 8'h0F);
        hold_rst = 1'h0;
        for (i = 0; i < 200 && reset_pin_n_in !== 1'h1; i++)
            tick(1);
        if (i == 200)
        begin
            err_total++;
            tally_and_finish();
        end
        tick(6);
    endtask
    initial
    begin
        tick(12);
        rst_n_in = 1'h1;
        tick(6);
        stat(4'hF, 3'h0);
        chk({5'h0, state_out}, 8'h01);
        for (int m = 0; m < 3; m++)
        begin
            mode_in = m[1:0];
            pin_reset();
            stat(4'h0, 3'h0);
            chk({5'h0, state_out}, 8'h02);
            for (int b = 0; b < 4; b++)
            begin
                local_error_in = 4'h1 << b;
                tick(6);
                stat(m == 1 ? 4'hF : (b < 2 ? 4'h3 : 4'hC), 3'h4);
                local_error_in = 4'h0;
                bootstrap_uv_in = 4'h1 << b;
                tick(6);
                stat(4'h1 << b, 3'h4);
                bootstrap_uv_in = 4'h0;
                tick(6);
                stat(4'h0, 3'h0);
            end
        end
        temp_warn_low_in = 1'h1;
        tick(6);
        stat(4'h0, 3'h2);
        temp_warn_high_in = 1'h1;
        tick(6);
        stat(4'h0, 3'h3);
        temp_warn_low_in = 1'h0;
        temp_warn_high_in = 1'h0;
        for (int f = 0; f < 4; f++)
        begin
            {overtemp_error_in, overload_protect_in} = f < 2 ? 2'h1 << f[0] : 2'h0;
            {gate_drive_supply_ok_in, common_supply_ok_in} = f > 1 ? 2'h1 << f[0] : 2'h3;
            tick(6);
            {overtemp_error_in, overload_protect_in} = 2'h0;
            tick(6);
            stat(4'hF, 3'h4);
            chk({5'h0, state_out}, f < 2 ? 8'h04 : 8'h02);
            {gate_drive_supply_ok_in, common_supply_ok_in} = 2'h3;
            tick(6);
            if (f < 2)
                pin_reset();
            stat(4'h0, 3'h0);
        end
        tally_and_finish();
    end
endmodule // afr_fault_ctrl_tb_top
